// file: core/xsie_pkg.sv
// package for the extended stack instruction executor
package xsie_pkg;
    localparam int ADDR_W = 12;
    localparam int PC_W = 21;
    localparam logic [15:0] OP_CALL_ACC = 16'h0014;
    localparam logic [7:0] OP_MOVE_HI = 8'heb;
    localparam logic [7:0] OP_PUSH_HI = 8'hea;
    localparam logic [7:0] OP_SUB_HI = 8'he9;
    localparam logic [3:0] OP_SECOND_HI = 4'hf;
    localparam logic [1:0] PTR_SEL_STACK = 2'h2;
    localparam logic [1:0] PTR_SEL_ILLEGAL = 2'h3;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [11:0] PTR_ONE = 12'h001;
    // indirect data ports sit at fixed addresses in the top page
    localparam logic [11:0] IND_BASE0 = 12'hfef;
    localparam logic [11:0] IND_BASE1 = 12'hfe7;
    localparam logic [11:0] IND_BASE2 = 12'hfdf;
    localparam logic [3:0] IND_SPAN = 4'h5;

    typedef struct packed {
        logic we;
        logic re;
        logic [11:0] addr;
        logic [7:0] wdata;
    } xsie_mem_t;

    typedef struct packed {
        logic push;
        logic [20:0] ret_addr;
        logic load;
        logic [20:0] target;
    } xsie_pc_t;
endpackage : xsie_pkg

// file: core/xsie_exec.sv
// executor for call via accumulator, indexed moves, literal push and pointer subtract
// Overview of operation
// RULE1 - call pushes program counter plus two
// RULE2 - pc low from accumulator, high/upper from latches
// RULE3 - call takes two cycles, second is idle
// RULE4 - call leaves accumulator, flags, bank unchanged
// RULE5 - move-to-file source is stack pointer plus offset
// RULE6 - move-to-file destination is 12-bit absolute
// RULE7 - indexed move uses two stack offsets
// RULE8 - programs never target pc low or stack top
// RULE9 - indirect source reads as zero
// RULE10 - indirect indexed destination makes a no-op
// RULE11 - push literal stores then decrements stack pointer
// RULE12 - subtract six-bit literal from selected pointer
// RULE13 - subtract decode 1110 1001, no flags touched
// RULE14 - moves two words two cycles, push one
`timescale 1ns/1ps
module xsie_exec
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] pc_now,
    input wire logic [7:0] accumulator_reg,
    input wire logic [7:0] jump_latch_high,
    input wire logic [7:0] jump_latch_upper,
    input wire logic [7:0] mem_rdata,
    output logic busy,
    output xsie_pkg::xsie_mem_t mem_o,
    output xsie_pkg::xsie_pc_t pc_o,
    output logic [11:0] file_select_pointer0,
    output logic [11:0] file_select_pointer1,
    output logic [11:0] software_stack_pointer
);

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic is_indirect(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        if ((a >= xsie_pkg::IND_BASE0) && (a < xsie_pkg::IND_BASE0 + 12'(xsie_pkg::IND_SPAN)))
            hit = 1'b1;
        if ((a >= xsie_pkg::IND_BASE1) && (a < xsie_pkg::IND_BASE1 + 12'(xsie_pkg::IND_SPAN)))
            hit = 1'b1;
        if ((a >= xsie_pkg::IND_BASE2) && (a < xsie_pkg::IND_BASE2 + 12'(xsie_pkg::IND_SPAN)))
            hit = 1'b1;
        return hit;
    endfunction : is_indirect

    function automatic logic [11:0] stack_rel(input logic [11:0] sp, input logic [6:0] off);
        return sp + {5'h00, off};
    endfunction : stack_rel

    // ****************************************************
    // state
    // ****************************************************
    typedef enum logic [1:0] {XSIE_IDLE, XSIE_CALL2, XSIE_MOVE2} xsie_state_t;
    xsie_state_t state_r;
    logic [7:0] src_data_r;
    logic move_to_stack_r;

    wire logic [7:0] op_hi = instr_word[15:8];
    wire logic take = instr_valid && (state_r == XSIE_IDLE);
    wire logic dec_call = take && (instr_word == xsie_pkg::OP_CALL_ACC);
    wire logic dec_move = take && (op_hi == xsie_pkg::OP_MOVE_HI);
    wire logic dec_push = take && (op_hi == xsie_pkg::OP_PUSH_HI);
    // selector 3 is the subtract-and-return form, handled elsewhere
    wire logic dec_sub = take && (op_hi == xsie_pkg::OP_SUB_HI) && // see RULE13
        (instr_word[7:6] != xsie_pkg::PTR_SEL_ILLEGAL);
    wire logic second_ok = instr_valid && (instr_word[15:12] == xsie_pkg::OP_SECOND_HI);
    wire logic [11:0] src_addr = stack_rel(software_stack_pointer, instr_word[6:0]); // see RULE5
    wire logic [11:0] dst_idx = stack_rel(software_stack_pointer, instr_word[6:0]); // see RULE7
    wire logic [11:0] dst_addr = move_to_stack_r ? dst_idx : instr_word[11:0]; // see RULE6
    wire logic dst_block = move_to_stack_r && is_indirect(dst_idx); // see RULE10

    assign busy = (state_r != XSIE_IDLE);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state_r <= XSIE_IDLE;
        else if (dec_call)
            state_r <= XSIE_CALL2; // see RULE3
        else if (dec_move)
            state_r <= XSIE_MOVE2; // see RULE14
        else if (state_r == XSIE_CALL2)
            state_r <= XSIE_IDLE;
        else if ((state_r == XSIE_MOVE2) && second_ok)
            state_r <= XSIE_IDLE;
    end

    // ****************************************************
    // source capture
    // ****************************************************
    // memory read is combinational, so data is caught in the first word's cycle
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            src_data_r <= xsie_pkg::DATA_ZERO;
            move_to_stack_r <= 1'b0;
        end
        else if (dec_move)
        begin
            src_data_r <= is_indirect(src_addr) ? xsie_pkg::DATA_ZERO : mem_rdata; // see RULE9
            move_to_stack_r <= instr_word[7]; // see RULE7
        end
    end

    // ****************************************************
    // memory port
    // ****************************************************
    always_comb
    begin
        mem_o = '0;
        if (dec_move)
        begin
            mem_o.re = 1'b1;
            mem_o.addr = src_addr;
        end
        else if (dec_push)
        begin
            mem_o.we = 1'b1; // see RULE11
            mem_o.addr = software_stack_pointer;
            mem_o.wdata = instr_word[7:0];
        end
        else if ((state_r == XSIE_MOVE2) && second_ok)
        begin
            // destination must never be pc low or stack top, left to software
            mem_o.we = !dst_block; // see RULE10
            mem_o.addr = dst_addr;
            mem_o.wdata = src_data_r;
        end
    end

    // ****************************************************
    // program counter and return stack
    // ****************************************************
    // accumulator, flags and bank select are only read here, never driven
    always_comb
    begin
        pc_o = '0;
        if (dec_call)
        begin
            pc_o.push = 1'b1; // see RULE1
            pc_o.ret_addr = pc_now + xsie_pkg::PC_STEP;
            pc_o.load = 1'b1; // see RULE2
            pc_o.target = {jump_latch_upper[4:0], jump_latch_high, accumulator_reg}; // see RULE4
        end
    end

    // ****************************************************
    // pointers
    // ****************************************************
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            file_select_pointer0 <= '0;
            file_select_pointer1 <= '0;
            software_stack_pointer <= '0;
        end
        else if (dec_push)
            software_stack_pointer <= software_stack_pointer - xsie_pkg::PTR_ONE; // see RULE11
        else if (dec_sub)
        begin
            unique case (instr_word[7:6]) // see RULE12
                2'h0: file_select_pointer0 <= file_select_pointer0 - {6'h00, instr_word[5:0]};
                2'h1: file_select_pointer1 <= file_select_pointer1 - {6'h00, instr_word[5:0]};
                default:
                    software_stack_pointer <= software_stack_pointer - {6'h00, instr_word[5:0]};
            endcase
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    sequence s_call_taken;
        dec_call;
    endsequence

    property p_call_push;
        @(posedge mclk) disable iff (!resetn)
        dec_call |-> pc_o.push && (pc_o.ret_addr == pc_now + xsie_pkg::PC_STEP);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call return addr wrong"); // see RULE1

    property p_call_target;
        @(posedge mclk) disable iff (!resetn)
        dec_call |-> pc_o.target[7:0] == accumulator_reg && pc_o.target[15:8] == jump_latch_high;
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target wrong"); // see RULE2

    property p_call_two;
        @(posedge mclk) disable iff (!resetn)
        s_call_taken |=> busy && !mem_o.we ##1 !busy;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not two cycles"); // see RULE3

    property p_call_quiet;
        @(posedge mclk) disable iff (!resetn)
        dec_call |-> !mem_o.we;
    endproperty
    a_call_quiet: assert property (p_call_quiet) else $error("call wrote memory"); // see RULE4

    property p_move_src;
        @(posedge mclk) disable iff (!resetn)
        dec_move |-> mem_o.re && mem_o.addr == software_stack_pointer + {5'h00, instr_word[6:0]};
    endproperty
    a_move_src: assert property (p_move_src) else $error("move source address wrong"); // see RULE5

    property p_move_abs;
        @(posedge mclk) disable iff (!resetn)
        (state_r == XSIE_MOVE2) && second_ok && !move_to_stack_r
            |-> mem_o.we && mem_o.addr == instr_word[11:0];
    endproperty
    a_move_abs: assert property (p_move_abs) else $error("absolute dest wrong"); // see RULE6

    property p_move_zero;
        @(posedge mclk) disable iff (!resetn)
        dec_move && is_indirect(src_addr) |=> src_data_r == xsie_pkg::DATA_ZERO;
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("indirect source read"); // see RULE9

    property p_move_nop;
        @(posedge mclk) disable iff (!resetn)
        (state_r == XSIE_MOVE2) && move_to_stack_r && is_indirect(dst_idx) |-> !mem_o.we;
    endproperty
    a_move_nop: assert property (p_move_nop) else $error("indirect dest written"); // see RULE10

    property p_push;
        @(posedge mclk) disable iff (!resetn)
        dec_push |-> mem_o.we ##1
            software_stack_pointer == $past(software_stack_pointer) - 12'h001;
    endproperty
    a_push: assert property (p_push) else $error("push pointer not decremented"); // see RULE11

    property p_sub;
        @(posedge mclk) disable iff (!resetn)
        dec_sub && instr_word[7:6] == 2'h0
            |=> file_select_pointer0 + {6'h00, $past(instr_word[5:0])}
                == $past(file_select_pointer0);
    endproperty
    a_sub: assert property (p_sub) else $error("pointer subtract wrong"); // see RULE12

    property p_sub_one;
        @(posedge mclk) disable iff (!resetn)
        dec_sub |=> !busy;
    endproperty
    a_sub_one: assert property (p_sub_one) else $error("subtract not one cycle"); // see RULE13

    sequence s_move_first;
        dec_move;
    endsequence

    sequence s_move_second;
        (state_r == XSIE_MOVE2) && second_ok;
    endsequence

    // back-to-back words with a plain source and a writable destination
    sequence s_move_clean;
        (dec_move && !is_indirect(src_addr)) ##1
            ((state_r == XSIE_MOVE2) && second_ok && !dst_block);
    endsequence

    property p_move_two;
        @(posedge mclk) disable iff (!resetn)
        s_move_first |=> busy;
    endproperty
    a_move_two: assert property (p_move_two) else $error("move not two words"); // see RULE14

    property p_move_done;
        @(posedge mclk) disable iff (!resetn)
        s_move_second |=> !busy;
    endproperty
    a_move_done: assert property (p_move_done) else $error("move overran"); // see RULE14

    property p_move_data;
        @(posedge mclk) disable iff (!resetn)
        s_move_clean |-> mem_o.we && (mem_o.wdata == $past(mem_rdata));
    endproperty
    a_move_data: assert property (p_move_data) else $error("moved data wrong"); // see RULE5

    property p_move_idx;
        @(posedge mclk) disable iff (!resetn)
        (state_r == XSIE_MOVE2) && second_ok && move_to_stack_r && !is_indirect(dst_idx)
            |-> mem_o.we && (mem_o.addr == software_stack_pointer + {5'h00, instr_word[6:0]});
    endproperty
    a_move_idx: assert property (p_move_idx) else $error("indexed dest wrong"); // see RULE7

    property p_push_store;
        @(posedge mclk) disable iff (!resetn)
        dec_push |-> (mem_o.addr == software_stack_pointer) && (mem_o.wdata == instr_word[7:0]);
    endproperty
    a_push_store: assert property (p_push_store) else $error("push store wrong"); // see RULE11

    property p_push_one;
        @(posedge mclk) disable iff (!resetn)
        dec_push |=> !busy;
    endproperty
    a_push_one: assert property (p_push_one) else $error("push not one cycle"); // see RULE14

    property p_call_upper;
        @(posedge mclk) disable iff (!resetn)
        dec_call |-> pc_o.load && (pc_o.target[20:16] == jump_latch_upper[4:0]);
    endproperty
    a_call_upper: assert property (p_call_upper) else $error("call upper wrong"); // see RULE2

    property p_sub_stack;
        @(posedge mclk) disable iff (!resetn)
        dec_sub && (instr_word[7:6] == xsie_pkg::PTR_SEL_STACK)
            |=> software_stack_pointer + {6'h00, $past(instr_word[5:0])}
                == $past(software_stack_pointer);
    endproperty
    a_sub_stack: assert property (p_sub_stack) else $error("sp subtract wrong"); // see RULE12

    // selector 3 belongs to the subtract-and-return form, so nothing may move here
    property p_sub_hold;
        @(posedge mclk) disable iff (!resetn)
        take && (op_hi == xsie_pkg::OP_SUB_HI) && (instr_word[7:6] == xsie_pkg::PTR_SEL_ILLEGAL)
            |=> $stable(software_stack_pointer);
    endproperty
    a_sub_hold: assert property (p_sub_hold) else $error("selector 3 acted"); // see RULE13

    property p_sub_quiet;
        @(posedge mclk) disable iff (!resetn)
        dec_sub |-> !mem_o.we && !mem_o.re && !pc_o.push && !pc_o.load;
    endproperty
    a_sub_quiet: assert property (p_sub_quiet) else $error("sub touched bus"); // see RULE13

endmodule : xsie_exec

// file: testbench/tb_xsie_exec.sv
// self-checking bench for the extended stack instruction executor
`timescale 1ns/1ps
module tb_xsie_exec;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [20:0] pc_now = 21'h000000;
    logic [7:0] accumulator_reg = 8'h00;
    logic [7:0] jump_latch_high = 8'h00;
    logic [7:0] jump_latch_upper = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic busy;
    xsie_pkg::xsie_mem_t mem_o;
    xsie_pkg::xsie_pc_t pc_o;
    logic [11:0] file_select_pointer0, file_select_pointer1, software_stack_pointer;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int ptr_m [3] = '{0, 0, 0};
    int k, z, d, r, pcv, src, seed_v;
    // pc low and the return stack top sit in this top slice; the placement is arbitrary
    localparam int CORE_REG_LO = 12'hff8;

    xsie_exec dut_u (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
        .instr_word(instr_word), .pc_now(pc_now), .accumulator_reg(accumulator_reg),
        .jump_latch_high(jump_latch_high), .jump_latch_upper(jump_latch_upper),
        .mem_rdata(mem_rdata), .busy(busy), .mem_o(mem_o), .pc_o(pc_o),
        .file_select_pointer0(file_select_pointer0),
        .file_select_pointer1(file_select_pointer1),
        .software_stack_pointer(software_stack_pointer));

    always #50 mclk = ~mclk;

    // ***************************************************************
    // checking helpers
    // ***************************************************************
    task automatic close_out;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic bit is_ind(input int a);
        return (a >= xsie_pkg::IND_BASE0 && a < xsie_pkg::IND_BASE0 + xsie_pkg::IND_SPAN) ||
            (a >= xsie_pkg::IND_BASE1 && a < xsie_pkg::IND_BASE1 + xsie_pkg::IND_SPAN) ||
            (a >= xsie_pkg::IND_BASE2 && a < xsie_pkg::IND_BASE2 + xsie_pkg::IND_SPAN);
    endfunction : is_ind

    // pointers seen here reflect every word taken before this one
    task automatic issue(input logic [15:0] w, input logic [7:0] rd, input logic [20:0] pc);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        mem_rdata <= rd;
        pc_now <= pc;
        @(negedge mclk);
        chk("fsp0", ptr_m[0], file_select_pointer0);
        chk("fsp1", ptr_m[1], file_select_pointer1);
        chk("ssp", ptr_m[2], software_stack_pointer);
    endtask : issue

    // one indexed move; dz below zero means an absolute destination
    task automatic move(input int zs, input int dz, input int dabs, input int rd);
        int dst;
        // software keeps both moves off pc low and the return stack top
        if ((dz < 0) && (dabs >= CORE_REG_LO))
            dabs = dabs - 8;
        if ((dz >= 0) && (((ptr_m[2] + dz) & 12'hfff) >= CORE_REG_LO))
            dz = (dz + 8) % 128;
        src = (ptr_m[2] + zs) & 12'hfff;
        dst = (dz < 0) ? dabs : ((ptr_m[2] + dz) & 12'hfff);
        issue({xsie_pkg::OP_MOVE_HI, 1'(dz >= 0), 7'(zs)}, 8'(rd), 21'h0);
        chk("src re", 1, mem_o.re);
        chk("src addr", src, mem_o.addr);
        issue((dz < 0) ? {4'hf, 12'(dabs)} : {4'hf, 5'($urandom), 7'(dz)}, 8'h00, 21'h0);
        chk("busy", 1, busy);
        chk("dst we", (dz < 0) || !is_ind(dst), mem_o.we);
        if (mem_o.we === 1'b1)
        begin
            chk("dst addr", dst, mem_o.addr);
            chk("dst data", is_ind(src) ? 0 : rd, mem_o.wdata);
        end
    endtask : move

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            close_out();
        end
    end

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial
    begin
        seed_v = $urandom(32'h5e9a);
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        // park the stack pointer on the lowest indirect port
        issue({xsie_pkg::OP_SUB_HI, 2'h2, 6'h21}, 8'h00, 21'h0);
        ptr_m[2] = 12'hfdf;
        move(0, 32, 0, 8'h5a);
        move(5, 8, 0, 8'h3c);
        for (int i = 0; i < 150; i++)
        begin
            // kept positive so that the model's modulo arithmetic sees the raw bits
            k = $urandom & 32'h00ffffff;
            r = $urandom % 256;
            case ($urandom % 5)
                0:
                begin
                    issue({xsie_pkg::OP_SUB_HI, 8'(k)}, 8'(r), 21'h0);
                    chk("sub we", 0, mem_o.we);
                    if ((k >> 6) % 4 != 3)
                        ptr_m[(k >> 6) % 4] = (ptr_m[(k >> 6) % 4] - k % 64) & 12'hfff;
                end
                1:
                begin
                    issue({xsie_pkg::OP_PUSH_HI, 8'(k)}, 8'(r), 21'h0);
                    chk("push we", 1, mem_o.we);
                    chk("push addr", ptr_m[2], mem_o.addr);
                    chk("push data", k % 256, mem_o.wdata);
                    ptr_m[2] = (ptr_m[2] - 1) & 12'hfff;
                end
                2:
                begin
                    pcv = $urandom % (1 << 21);
                    accumulator_reg <= 8'(k);
                    jump_latch_high <= 8'(k >> 8);
                    jump_latch_upper <= 8'(k >> 16);
                    issue(xsie_pkg::OP_CALL_ACC, 8'(r), 21'(pcv));
                    chk("push", 1, pc_o.push);
                    chk("ret", (pcv + 2) % (1 << 21), pc_o.ret_addr);
                    chk("load", 1, pc_o.load);
                    chk("target", {k[20:16], k[15:8], k[7:0]}, pc_o.target);
                    issue({xsie_pkg::OP_PUSH_HI, 8'(r)}, 8'(r), 21'h0);
                    chk("idle", 32'h4, {busy, pc_o.push, pc_o.load});
                    chk("idle we", 0, mem_o.we);
                end
                3: move(k % 128, -1, (k >> 8) % 4096, r);
                default: move(k % 128, (k >> 8) % 128, 0, r);
            endcase
        end
        issue(16'h0000, 8'h00, 21'h0);
        close_out();
    end
endmodule : tb_xsie_exec
